// [verilog/fips_pkg.sv]
// Behaviour
// - Select 001 plus program trigger erases the addressed page, then trigger clears.
// - Select 000 is write mode; trigger moves the write buffer into flash.
// - Program trigger stays high for the 2.2 ms operation, then drops itself.
// - CPU is held stalled while an erase or write runs.
// - Erase and write are refused unless the erase/write enabled flag is set.
// - Erase always clears a whole page.
// - Write commits the whole buffer as one page; addresses stay inside it.
// - Buffer clear bit empties the write buffer.
// - A page may be written again without erase, for retries.
// - Select 011 is read mode; read enable bit must be set.
// - Read trigger fetches the addressed word into the data registers.
// - Read trigger clears after three instruction cycles; CPU stalls meanwhile.
// - Reads need no unlock.
// - Buffer holds 32 words; pointer steps on high byte, saturates at last.
// - Unlock: select 110, set unlock start, which starts the unlock timer.
// - Key 00,0D,C3 low and 04,09,40 high sets the enabled flag.
// - Unlock start clears when the timer expires, whatever the key.
//
`default_nettype none
package fips_pkg;

    // ****************************************
    // Register map
    // ****************************************
    localparam logic [7:0] FIPS_OFS_CTRL = 8'h00;
    localparam logic [7:0] FIPS_OFS_ADDR_LOW = 8'h04;
    localparam logic [7:0] FIPS_OFS_ADDR_HIGH = 8'h08;
    localparam logic [7:0] FIPS_OFS_WORD_LOW = 8'h0c;
    localparam logic [7:0] FIPS_OFS_WORD_HIGH = 8'h10;
    localparam logic [7:0] FIPS_OFS_KEY_LOW = 8'h14;
    localparam logic [7:0] FIPS_OFS_KEY_HIGH = 8'h20;
    localparam logic [7:0] FIPS_OFS_STEP = 8'h04;

    // ****************************************
    // Control fields
    // ****************************************
    localparam int FIPS_OPSEL_LSB = 0;
    localparam int FIPS_RDEN_BIT = 3;
    localparam int FIPS_PTRIG_BIT = 4;
    localparam int FIPS_RTRIG_BIT = 5;
    localparam int FIPS_UNLK_BIT = 6;
    localparam int FIPS_BCLR_BIT = 7;
    localparam int FIPS_EWEN_BIT = 8;
    localparam logic [2:0] FIPS_OP_WRITE = 3'h0;
    localparam logic [2:0] FIPS_OP_ERASE = 3'h1;
    localparam logic [2:0] FIPS_OP_READ = 3'h3;
    localparam logic [2:0] FIPS_OP_UNLOCK = 3'h6;
    localparam logic [2:0] FIPS_OPSEL_RST = 3'h0;
    localparam logic [15:0] FIPS_WORD_RST = 16'h0000;
    localparam logic [2:0][7:0] FIPS_KEY_LOW = {8'hc3, 8'h0d, 8'h00};
    localparam logic [2:0][7:0] FIPS_KEY_HIGH = {8'h40, 8'h09, 8'h04};

    // ****************************************
    // Geometry and timing
    // ****************************************
    localparam int FIPS_PAGE_WORDS = 32;
    localparam logic [4:0] FIPS_LAST_WORD = 5'h1f;
    localparam int FIPS_CLK_MHZ = 250;
    localparam int FIPS_PROG_TIME_US = 2200;
    localparam int FIPS_PROG_CYCLES = FIPS_PROG_TIME_US * FIPS_CLK_MHZ;
    localparam int FIPS_READ_INSTR = 3;
    localparam int FIPS_CLKS_PER_INSTR = 1;
    localparam int FIPS_READ_CLKS = FIPS_READ_INSTR * FIPS_CLKS_PER_INSTR;
    localparam int FIPS_UNLOCK_CYCLES = 1024;

    typedef enum logic [1:0] {
        FIPS_ST_IDLE = 2'b00,
        FIPS_ST_ERASE = 2'b01,
        FIPS_ST_PROG = 2'b10,
        FIPS_ST_READ = 2'b11
    } fips_state_type;

endpackage
`default_nettype wire

// [verilog/fips_wbuf_if.sv]
`timescale 1ns/100ps
`default_nettype none
interface fips_wbuf_if;
    logic load;
    logic [15:0] load_data;
    logic set_ptr;
    logic [4:0] ptr_init;
    logic clear;
    logic [4:0] rd_idx;
    logic [15:0] rd_data;
    logic [4:0] ptr;
    modport ctrl (
        output load, load_data, set_ptr, ptr_init, clear, rd_idx,
        input rd_data, ptr
    );
    modport store (
        input load, load_data, set_ptr, ptr_init, clear, rd_idx,
        output rd_data, ptr
    );
endinterface
`default_nettype wire

// [verilog/fips_wbuf.sv]
`timescale 1ns/100ps
`default_nettype none
module fips_wbuf (
    input wire logic i_clk,
    input wire logic i_rst_n,
    fips_wbuf_if.store wb
);
    import fips_pkg::*;

    logic [15:0] mem [FIPS_PAGE_WORDS];
    logic [4:0] ptr_reg;

    // ****************************************
    // Word pointer
    // ****************************************
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            ptr_reg <= 5'h00;
        end else if (wb.clear) begin
            ptr_reg <= 5'h00;
        end else if (wb.set_ptr) begin
            ptr_reg <= wb.ptr_init;
        end else if (wb.load && ptr_reg != FIPS_LAST_WORD) begin
            ptr_reg <= ptr_reg + 5'h01;
        end
    end

    // ****************************************
    // Storage, one word per entry
    // ****************************************
    for (genvar i = 0; i < FIPS_PAGE_WORDS; i++) begin : g_word
        always_ff @(posedge i_clk or negedge i_rst_n) begin
            if (!i_rst_n) begin
                mem[i] <= FIPS_WORD_RST;
            end else if (wb.clear) begin
                mem[i] <= FIPS_WORD_RST;
            end else if (wb.load && ptr_reg == 5'(i)) begin
                mem[i] <= wb.load_data;
            end
        end
    end

    assign wb.rd_data = mem[wb.rd_idx];
    assign wb.ptr = ptr_reg;

    a_clear_empties: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        wb.clear |=> (ptr_reg == 5'h00 && mem[0] == FIPS_WORD_RST))
        else $error("Buffer clear did not empty buffer");

    a_ptr_saturates: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        (wb.load && !wb.clear && !wb.set_ptr && ptr_reg == FIPS_LAST_WORD)
        |=> ptr_reg == FIPS_LAST_WORD)
        else $error("Buffer pointer passed page end");

    a_ptr_steps: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        (wb.load && !wb.clear && !wb.set_ptr && ptr_reg != FIPS_LAST_WORD)
        |=> ptr_reg == $past(ptr_reg) + 5'h01)
        else $error("Buffer pointer did not step");
endmodule
`default_nettype wire

// [verilog/fips_sequencer.sv]
// Added by the designer: the AHB-Lite interface to the registers and the placing of the registers.
`timescale 1ns/100ps
`default_nettype none
module fips_sequencer #(
    parameter int PROG_CYCLES = fips_pkg::FIPS_PROG_CYCLES,
    parameter int UNLOCK_CYCLES = fips_pkg::FIPS_UNLOCK_CYCLES
) (
    input wire logic i_clk,
    input wire logic i_rst_n,
    input wire logic i_hsel,
    input wire logic [31:0] i_haddr,
    input wire logic [1:0] i_htrans,
    input wire logic i_hwrite,
    input wire logic [2:0] i_hsize,
    input wire logic [31:0] i_hwdata,
    input wire logic i_hready,
    output logic o_hreadyout,
    output logic o_hresp,
    output logic [31:0] o_hrdata,
    output logic o_fl_erase,
    output logic o_fl_wr,
    output logic o_fl_rd,
    output logic [12:0] o_fl_addr,
    output logic [15:0] o_fl_wdata,
    input wire logic [15:0] i_fl_rdata,
    output logic o_cpu_stall
);
    import fips_pkg::*;

    localparam logic [19:0] PROG_LAST = 20'(PROG_CYCLES - 1);
    localparam logic [19:0] READ_LAST = 20'(FIPS_READ_CLKS - 1);
    localparam logic [19:0] UNLOCK_LAST = 20'(UNLOCK_CYCLES - 1);
    localparam logic [19:0] PAGE_END = 20'(FIPS_PAGE_WORDS);
    fips_wbuf_if wb ();
    fips_wbuf u_wbuf (
        .i_clk(i_clk),
        .i_rst_n(i_rst_n),
        .wb(wb.store)
    );

    fips_state_type state_reg;
    logic [19:0] cnt_reg;
    logic [19:0] ucnt_reg;
    logic wr_pend_reg;
    logic [7:0] wr_addr_reg;
    logic [31:0] hrdata_reg;
    logic [2:0] opsel_reg;
    logic rden_reg;
    logic ptrig_reg;
    logic rtrig_reg;
    logic unlk_reg;
    logic ewen_reg;
    logic [7:0] addr_low_reg;
    logic [4:0] addr_high_reg;
    logic [7:0] word_low_reg;
    logic [7:0] word_high_reg;
    logic [2:0][7:0] key_low_reg;
    logic [2:0][7:0] key_high_reg;
    logic fl_erase_reg;
    logic fl_wr_reg;
    logic fl_rd_reg;
    logic [12:0] fl_addr_reg;
    logic [15:0] fl_wdata_reg;
    logic wr_ctrl;
    logic [2:0] wop;
    logic idle;
    logic prog_go;
    logic read_go;
    logic op_done;
    logic key_ok;
    logic [7:0] wofs;

    // ****************************************
    // AHB-Lite slave
    // ****************************************
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            wr_pend_reg <= 1'b0;
            wr_addr_reg <= 8'h00;
        end else if (i_hready) begin
            wr_pend_reg <= i_hsel && i_htrans[1] && i_hwrite;
            wr_addr_reg <= i_haddr[7:0];
        end
    end
    function automatic logic [31:0] read_mux(input logic [7:0] a);
        logic [31:0] v;
        v = 32'h0000_0000;
        if (a == FIPS_OFS_CTRL) begin
            v[FIPS_OPSEL_LSB +: 3] = opsel_reg;
            v[FIPS_RDEN_BIT] = rden_reg;
            v[FIPS_PTRIG_BIT] = ptrig_reg;
            v[FIPS_RTRIG_BIT] = rtrig_reg;
            v[FIPS_UNLK_BIT] = unlk_reg;
            v[FIPS_EWEN_BIT] = ewen_reg;
        end else if (a == FIPS_OFS_ADDR_LOW) begin
            v[7:0] = addr_low_reg;
        end else if (a == FIPS_OFS_ADDR_HIGH) begin
            v[4:0] = addr_high_reg;
        end else if (a == FIPS_OFS_WORD_LOW) begin
            v[7:0] = word_low_reg;
        end else if (a == FIPS_OFS_WORD_HIGH) begin
            v[7:0] = word_high_reg;
        end else begin
            for (int k = 0; k < 3; k++) begin
                if (a == FIPS_OFS_KEY_LOW + 8'(k) * FIPS_OFS_STEP) begin
                    v[7:0] = key_low_reg[k];
                end
                if (a == FIPS_OFS_KEY_HIGH + 8'(k) * FIPS_OFS_STEP) begin
                    v[7:0] = key_high_reg[k];
                end
            end
        end
        return v;
    endfunction
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            hrdata_reg <= 32'h0000_0000;
        end else if (i_hready && i_hsel && i_htrans[1] && !i_hwrite) begin
            hrdata_reg <= read_mux(i_haddr[7:0]);
        end
    end
    assign o_hreadyout = 1'b1;
    assign o_hresp = 1'b0;
    assign o_hrdata = hrdata_reg;

    // ****************************************
    // Command decode
    // ****************************************
    assign wofs = wr_addr_reg;
    assign wr_ctrl = wr_pend_reg && wofs == FIPS_OFS_CTRL;
    assign wop = i_hwdata[FIPS_OPSEL_LSB +: 3];
    assign idle = state_reg == FIPS_ST_IDLE;
    assign prog_go = wr_ctrl && i_hwdata[FIPS_PTRIG_BIT] && idle
        && ewen_reg
        && (wop == FIPS_OP_ERASE || wop == FIPS_OP_WRITE);
    assign read_go = wr_ctrl && i_hwdata[FIPS_RTRIG_BIT] && idle
        && wop == FIPS_OP_READ && i_hwdata[FIPS_RDEN_BIT];
    assign key_ok = key_low_reg == FIPS_KEY_LOW
        && key_high_reg == FIPS_KEY_HIGH;

    // ****************************************
    // Control register
    // ****************************************
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            opsel_reg <= FIPS_OPSEL_RST;
            rden_reg <= 1'b0;
        end else if (wr_ctrl && idle) begin
            opsel_reg <= wop;
            rden_reg <= i_hwdata[FIPS_RDEN_BIT];
        end
    end
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            ptrig_reg <= 1'b0;
        end else if (prog_go) begin
            ptrig_reg <= 1'b1;
        end else if (op_done && state_reg != FIPS_ST_READ) begin
            ptrig_reg <= 1'b0;
        end
    end
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            rtrig_reg <= 1'b0;
        end else if (read_go) begin
            rtrig_reg <= 1'b1;
        end else if (op_done && state_reg == FIPS_ST_READ) begin
            rtrig_reg <= 1'b0;
        end
    end

    // ****************************************
    // Unlock window and enable flag
    // ****************************************
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            unlk_reg <= 1'b0;
            ucnt_reg <= 20'h0_0000;
        end else if (unlk_reg) begin
            ucnt_reg <= ucnt_reg + 20'h0_0001;
            if (ucnt_reg == UNLOCK_LAST) begin
                unlk_reg <= 1'b0;
            end
        end else if (wr_ctrl && i_hwdata[FIPS_UNLK_BIT]
                     && wop == FIPS_OP_UNLOCK && idle) begin
            unlk_reg <= 1'b1;
            ucnt_reg <= 20'h0_0000;
        end
    end
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            ewen_reg <= 1'b0;
        end else if (unlk_reg && key_ok) begin
            ewen_reg <= 1'b1;
        end else if (wr_ctrl && !i_hwdata[FIPS_EWEN_BIT]) begin
            ewen_reg <= 1'b0;
        end
    end

    // ****************************************
    // Address, data and key registers
    // ****************************************
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            addr_low_reg <= 8'h00;
            addr_high_reg <= 5'h00;
        end else if (wr_pend_reg && idle) begin
            if (wofs == FIPS_OFS_ADDR_LOW) begin
                addr_low_reg <= i_hwdata[7:0];
            end else if (wofs == FIPS_OFS_ADDR_HIGH) begin
                addr_high_reg <= i_hwdata[4:0];
            end
        end
    end
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            word_low_reg <= 8'h00;
            word_high_reg <= 8'h00;
        end else if (op_done && state_reg == FIPS_ST_READ) begin
            word_low_reg <= i_fl_rdata[7:0];
            word_high_reg <= i_fl_rdata[15:8];
        end else if (wr_pend_reg && idle) begin
            if (wofs == FIPS_OFS_WORD_LOW) begin
                word_low_reg <= i_hwdata[7:0];
            end else if (wofs == FIPS_OFS_WORD_HIGH) begin
                word_high_reg <= i_hwdata[7:0];
            end
        end
    end
    for (genvar k = 0; k < 3; k++) begin : g_key
        always_ff @(posedge i_clk or negedge i_rst_n) begin
            if (!i_rst_n) begin
                key_low_reg[k] <= 8'h00;
                key_high_reg[k] <= 8'h00;
            end else if (wr_pend_reg) begin
                if (wofs == FIPS_OFS_KEY_LOW + 8'(k) * FIPS_OFS_STEP) begin
                    key_low_reg[k] <= i_hwdata[7:0];
                end else if (wofs == FIPS_OFS_KEY_HIGH
                             + 8'(k) * FIPS_OFS_STEP) begin
                    key_high_reg[k] <= i_hwdata[7:0];
                end
            end
        end
    end

    // ****************************************
    // Write buffer control
    // ****************************************
    assign wb.load = wr_pend_reg && idle && wofs == FIPS_OFS_WORD_HIGH
        && opsel_reg == FIPS_OP_WRITE;
    assign wb.load_data = {i_hwdata[7:0], word_low_reg};
    assign wb.set_ptr = wr_pend_reg && idle && wofs == FIPS_OFS_ADDR_LOW;
    assign wb.ptr_init = i_hwdata[4:0];
    assign wb.clear = wr_ctrl && idle && i_hwdata[FIPS_BCLR_BIT];
    assign wb.rd_idx = cnt_reg[4:0];

    // ****************************************
    // Operation sequencer
    // ****************************************
    always_comb begin
        case (state_reg)
            FIPS_ST_ERASE: op_done = cnt_reg == PROG_LAST;
            FIPS_ST_PROG: op_done = cnt_reg == PROG_LAST;
            FIPS_ST_READ: op_done = cnt_reg == READ_LAST;
            default: op_done = 1'b0;
        endcase
    end
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            state_reg <= FIPS_ST_IDLE;
            cnt_reg <= 20'h0_0000;
        end else begin
            case (state_reg)
                FIPS_ST_IDLE: begin
                    cnt_reg <= 20'h0_0000;
                    if (prog_go && wop == FIPS_OP_ERASE) begin
                        state_reg <= FIPS_ST_ERASE;
                    end else if (prog_go) begin
                        state_reg <= FIPS_ST_PROG;
                    end else if (read_go) begin
                        state_reg <= FIPS_ST_READ;
                    end
                end
                default: begin
                    cnt_reg <= cnt_reg + 20'h0_0001;
                    if (op_done) begin
                        state_reg <= FIPS_ST_IDLE;
                    end
                end
            endcase
        end
    end

    // ****************************************
    // Flash array strobes
    // ****************************************
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            fl_erase_reg <= 1'b0;
            fl_wr_reg <= 1'b0;
            fl_rd_reg <= 1'b0;
            fl_addr_reg <= 13'h0000;
            fl_wdata_reg <= 16'h0000;
        end else begin
            fl_erase_reg <= prog_go && wop == FIPS_OP_ERASE;
            fl_rd_reg <= read_go;
            fl_wr_reg <= state_reg == FIPS_ST_PROG
                && cnt_reg < PAGE_END;
            fl_wdata_reg <= wb.rd_data;
            if (state_reg == FIPS_ST_PROG) begin
                fl_addr_reg <= {addr_high_reg, addr_low_reg[7:5],
                                cnt_reg[4:0]};
            end else if (idle) begin
                fl_addr_reg <= {addr_high_reg, addr_low_reg};
            end
        end
    end

    assign o_fl_erase = fl_erase_reg;
    assign o_fl_wr = fl_wr_reg;
    assign o_fl_rd = fl_rd_reg;
    assign o_fl_addr = fl_erase_reg ? {fl_addr_reg[12:5], 5'h00}
                                    : fl_addr_reg;
    assign o_fl_wdata = fl_wdata_reg;
    assign o_cpu_stall = !idle;

    // ****************************************
    // Checks
    // ****************************************
    a_erase_needs_flag: assert property (@(posedge i_clk)
        disable iff (!i_rst_n) (o_fl_erase || $rose(ptrig_reg)) |->
        $past(ewen_reg))
        else $error("Erase or write started while locked");
    a_ptrig_full_time: assert property (@(posedge i_clk)
        disable iff (!i_rst_n) $fell(ptrig_reg) |->
        $past(cnt_reg) == PROG_LAST)
        else $error("Program trigger dropped early");
    a_stall_follows: assert property (@(posedge i_clk)
        disable iff (!i_rst_n) o_cpu_stall == (ptrig_reg || rtrig_reg))
        else $error("CPU stall not tied to trigger bits");
    a_read_three: assert property (@(posedge i_clk)
        disable iff (!i_rst_n) $rose(rtrig_reg) |->
        rtrig_reg [*3] ##1 !rtrig_reg)
        else $error("Read trigger wrong length");
    a_read_unlocked: assert property (@(posedge i_clk)
        disable iff (!i_rst_n) read_go |=> (rtrig_reg && o_fl_rd))
        else $error("Read refused");
    a_page_bound: assert property (@(posedge i_clk)
        disable iff (!i_rst_n) (o_fl_wr && $past(o_fl_wr)) |->
        (o_fl_addr[12:5] == $past(o_fl_addr[12:5])
        && o_fl_addr[4:0] == $past(o_fl_addr[4:0]) + 5'h01))
        else $error("Write left page");
    a_unlock_expire: assert property (@(posedge i_clk)
        disable iff (!i_rst_n) $fell(unlk_reg) |->
        $past(ucnt_reg) == UNLOCK_LAST)
        else $error("Unlock window wrong length");
    a_key_enables: assert property (@(posedge i_clk)
        disable iff (!i_rst_n) (unlk_reg && key_ok) |=> ewen_reg)
        else $error("Key match did not enable");
    a_busy_ignored: assert property (@(posedge i_clk)
        disable iff (!i_rst_n) (!idle && !op_done) |=>
        state_reg == $past(state_reg))
        else $error("Running operation disturbed");
    a_read_fetch: assert property (@(posedge i_clk)
        disable iff (!i_rst_n) (op_done && state_reg == FIPS_ST_READ) |=>
        {word_high_reg, word_low_reg} == $past(i_fl_rdata))
        else $error("Read data not captured");
endmodule
`default_nettype wire

// [verification/fips_flash_model.sv]
`timescale 1ns/100ps
`default_nettype none
module fips_flash_model #(
    parameter logic [15:0] PAT = 16'ha5a5
) (
    input wire logic i_clk,
    input wire logic i_erase,
    input wire logic i_wr,
    input wire logic i_rd,
    input wire logic [12:0] i_addr,
    input wire logic [15:0] i_wdata,
    output logic [15:0] o_rdata
);
    // ****************************************
    // Flash array
    // ****************************************
    logic [15:0] mem [8192];
    int hold = 0;
    initial begin
        for (int i = 0; i < 8192; i++) begin
            mem[i] = i[15:0] ^ PAT;
        end
    end
    always @(posedge i_clk) begin
        if (i_erase) begin
            for (int i = 0; i < 32; i++) begin
                mem[{i_addr[12:5], i[4:0]}] <= 16'h0000;
            end
        end
        if (i_wr) begin
            mem[i_addr] <= i_wdata;
        end
        if (i_rd) begin
            o_rdata <= mem[i_addr];
            hold <= 3;
        end else if (hold > 0) begin
            hold <= hold - 1;
        end else begin
            o_rdata <= ~o_rdata;
        end
    end
endmodule
`default_nettype wire

// [verification/fips_sequencer_tb.sv]
`timescale 1ns/100ps
`default_nettype none
module fips_sequencer_tb import fips_pkg::*;;
    // ****************************************
    // Bench
    // ****************************************
    localparam logic [15:0] PAT = 16'ha5a5;
    logic clk = 0, rst_n = 0, hsel = 0, hwrite = 0, hready;
    logic [31:0] haddr = 0, hwdata = 0, hrdata, q;
    logic [1:0] htrans = 0;
    logic fl_erase, fl_wr, fl_rd, stall, hresp;
    logic [12:0] fl_addr;
    logic [15:0] fl_wdata, fl_rdata;
    int err_total = 0, samples_checked = 0;
    always #2 clk = ~clk;
    fips_sequencer #(.PROG_CYCLES(50), .UNLOCK_CYCLES(40)) i_dut (
        .i_clk(clk), .i_rst_n(rst_n), .i_hsel(hsel), .i_haddr(haddr),
        .i_htrans(htrans), .i_hwrite(hwrite), .i_hsize(3'h2),
        .i_hwdata(hwdata), .i_hready(hready), .o_hreadyout(hready),
        .o_hresp(hresp), .o_hrdata(hrdata), .o_fl_erase(fl_erase),
        .o_fl_wr(fl_wr), .o_fl_rd(fl_rd), .o_fl_addr(fl_addr),
        .o_fl_wdata(fl_wdata), .i_fl_rdata(fl_rdata), .o_cpu_stall(stall));
    fips_flash_model #(.PAT(PAT)) i_flash (
        .i_clk(clk), .i_erase(fl_erase), .i_wr(fl_wr), .i_rd(fl_rd),
        .i_addr(fl_addr), .i_wdata(fl_wdata), .o_rdata(fl_rdata));
    task automatic summarize();
        if (err_total == 0 && samples_checked > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            err_total++;
            $display("unexpected at %0t: got %h want %h", $time, got, exp);
        end
    endtask
    task automatic edge_wait();
        int n;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (hready !== 1'b1 && n < 100);
        if (hready !== 1'b1) begin
            err_total++;
            summarize();
        end
    endtask
    task automatic xfer(input logic w, input logic [7:0] a,
                        input logic [31:0] d, output logic [31:0] r);
        hsel <= 1'b1;
        htrans <= 2'b10;
        hwrite <= w;
        haddr <= {24'h000000, a};
        edge_wait();
        htrans <= 2'b00;
        hwdata <= d;
        edge_wait();
        chk({31'h0, hresp}, 32'h0000_0000);
        r = hrdata;
        @(posedge clk);
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] r;
        xfer(1'b1, a, d, r);
    endtask
    task automatic waitlow(input int b);
        int n;
        n = 0;
        do begin
            xfer(1'b0, FIPS_OFS_CTRL, 32'h0, q);
            n++;
        end while (q[b] !== 1'b0 && n < 200);
        if (q[b] !== 1'b0) begin
            err_total++;
            summarize();
        end
    endtask
    task automatic fread(input logic [12:0] a, input logic [15:0] exp);
        logic [31:0] lo;
        wr(FIPS_OFS_ADDR_HIGH, {27'h0, a[12:8]});
        wr(FIPS_OFS_ADDR_LOW, {24'h0, a[7:0]});
        wr(FIPS_OFS_CTRL, 32'h0000_012b);
        waitlow(FIPS_RTRIG_BIT);
        xfer(1'b0, FIPS_OFS_WORD_LOW, 32'h0, lo);
        xfer(1'b0, FIPS_OFS_WORD_HIGH, 32'h0, q);
        chk({q[7:0], lo[7:0]}, {16'h0000, exp});
    endtask
    task automatic prog(input logic [31:0] c);
        wr(FIPS_OFS_CTRL, c);
        chk({stall, 31'h0}, 32'h8000_0000);
        wr(FIPS_OFS_CTRL, 32'h0000_012b);
        xfer(1'b0, FIPS_OFS_CTRL, 32'h0, q);
        chk(q & 32'h0000_003f, 32'h0000_0010 | (c & 32'h0000_0007));
        waitlow(FIPS_PTRIG_BIT);
        chk({stall, 31'h0}, 32'h0000_0000);
    endtask
    initial begin
        repeat (10) @(posedge clk);
        rst_n <= 1'b1;
        xfer(1'b0, FIPS_OFS_CTRL, 32'h0, q);
        chk(q, 32'h0000_0000);
        fread(13'h0123, 13'h0123 ^ PAT);
        wr(FIPS_OFS_CTRL, 32'h0000_0011);
        xfer(1'b0, FIPS_OFS_CTRL, 32'h0, q);
        chk({q[4], stall, 30'h0}, 32'h0000_0000);
        for (int k = 0; k < 3; k++) begin
            wr(FIPS_OFS_KEY_LOW + 8'(4 * k), {24'h0, FIPS_KEY_LOW[k]});
            wr(FIPS_OFS_KEY_HIGH + 8'(4 * k), {24'h0, FIPS_KEY_HIGH[k]});
        end
        wr(FIPS_OFS_CTRL, 32'h0000_0046);
        waitlow(FIPS_UNLK_BIT);
        chk(q & 32'h0000_0140, 32'h0000_0100);
        prog(32'h0000_0111);
        fread(13'h0123, 16'h0000);
        fread(13'h013f, 16'h0000);
        fread(13'h0140, 13'h0140 ^ PAT);
        wr(FIPS_OFS_CTRL, 32'h0000_0100);
        wr(FIPS_OFS_ADDR_HIGH, 32'h0000_0001);
        wr(FIPS_OFS_ADDR_LOW, 32'h0000_0020);
        for (int i = 0; i < 33; i++) begin
            wr(FIPS_OFS_WORD_LOW, 32'(i));
            wr(FIPS_OFS_WORD_HIGH, 32'h0000_005c);
        end
        prog(32'h0000_0110);
        fread(13'h0120, 16'h5c00);
        fread(13'h013f, 16'h5c20);
        wr(FIPS_OFS_CTRL, 32'h0000_0180);
        wr(FIPS_OFS_ADDR_LOW, 32'h0000_0025);
        wr(FIPS_OFS_WORD_LOW, 32'h0000_0077);
        wr(FIPS_OFS_WORD_HIGH, 32'h0000_0066);
        prog(32'h0000_0110);
        fread(13'h0125, 16'h6677);
        fread(13'h0120, 16'h0000);
        wr(FIPS_OFS_CTRL, 32'h0000_0000);
        wr(FIPS_OFS_CTRL, 32'h0000_0011);
        xfer(1'b0, FIPS_OFS_CTRL, 32'h0, q);
        chk({q[8], q[4], stall, 29'h0}, 32'h0000_0000);
        summarize();
    end
endmodule
`default_nettype wire
